// ### design/pcr_control_two.sv
`timescale 1ns/100ps
// Operation
// - bit 6 shortens parallel-detect link-up
// - crossover modes force fast link-up bit
// - bit 5 forces full duplex, forced-100 partner
// - bit 5 clear uses standard duplex resolution
// - bit 4 lights lamp only for 100 full
// - bit 3 isolates outputs on 100 half
// - bit 2 enables idle receive symbol errors
// - odd-nibble end extends enable, flags error
// - bit 1 set disables odd-nibble check
// - bit 0 picks receive clock for data
module pcr_control_two #(
  parameter int unsigned PD_NORMAL_CYCLES = pcr_pkg::PD_NORMAL_CYC // parallel-detect wait
) (
  input wire logic pclk, // bus clock, 20 MHz
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction, 1 = write
  input wire logic [pcr_pkg::ADDR_W-1:0] paddr, // apb byte address
  input wire logic [pcr_pkg::DATA_W-1:0] pwdata, // apb write data
  output logic [pcr_pkg::DATA_W-1:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic link_up, // a link is established
  input wire logic speed_100, // link runs 100BASE-TX
  input wire logic pd_active, // parallel detection in progress
  input wire logic partner_forced_100, // partner seen as forced 100BASE-TX
  input wire logic std_full_duplex, // standard duplex resolution result
  input wire logic rx_idle, // receiver in idle state
  input wire logic rx_symbol_err, // receive symbol error seen
  input wire logic tx_en_in, // transmit enable from the mac
  input wire logic tx_er_in, // transmit error from the mac
  input wire logic tx_clk_tick, // one pulse per transmit nibble
  input wire logic [1:0] rxd_in, // reduced-interface receive data
  input wire logic ref_clk_tick, // reference clock input edge
  input wire logic rx_clk_tick, // receive clock edge
  output logic full_duplex, // resolved duplex
  output logic link_lamp, // link indicator drive
  output logic outputs_isolated, // media-independent outputs isolated
  output logic pd_link_ok, // parallel detect qualified the link
  output logic rx_err_out, // receive error toward the mac
  output logic tx_en_out, // transmit enable to the coder
  output logic tx_er_out, // transmit error to the coder
  output logic [1:0] rxd_out, // sampled receive data
  output logic rxd_strobe // sample pulse
);
  import pcr_pkg::*;

  // register state
  logic [6:0] ctrl_two_ff;
  logic [6:0] nxt_ctrl_two;
  logic [1:0] ctrl_one_ff;
  logic [1:0] nxt_ctrl_one;
  // bus answer state
  logic pready_ff;
  logic nxt_pready;
  logic pslverr_ff;
  logic nxt_pslverr;
  logic [DATA_W-1:0] prdata_ff;
  logic [DATA_W-1:0] nxt_prdata;
  // link result state
  logic fd_ff;
  logic nxt_fd;
  logic lamp_ff;
  logic nxt_lamp;
  logic iso_ff;
  logic nxt_iso;
  logic rx_err_ff;
  logic nxt_rx_err;
  // transmit tracker state
  pcr_tx_state_t tx_state_ff;
  pcr_tx_state_t nxt_tx_state;
  logic odd_ff;
  logic nxt_odd;
  logic tx_en_ff;
  logic nxt_tx_en;
  logic tx_er_ff;
  logic nxt_tx_er;
  // helpers
  logic [1:0] sel;
  logic wr_hit;
  logic xover_on;
  logic fd_now;
  logic [REG_W-1:0] status_word;
  logic pd_done;

  // one decode shared by the setup read and the access write
  assign sel = pcr_decode(paddr);
  assign wr_hit = psel && penable && pready_ff && pwrite;
  assign xover_on = ctrl_one_ff[1] | ctrl_one_ff[0];

  // status gathers what the block has resolved
  always_comb
  begin
    status_word = '0;
    status_word[ST_FD_BIT] = fd_ff;
    status_word[ST_LAMP_BIT] = lamp_ff;
    status_word[ST_ISO_BIT] = iso_ff;
    status_word[ST_PD_LINK_BIT] = pd_done;
    status_word[ST_TX_EXT_BIT] = tx_state_ff == TX_EXTEND;
  end

  // register writes land only at the access edge with ready high
  always_comb
  begin
    nxt_ctrl_two = ctrl_two_ff;
    nxt_ctrl_one = ctrl_one_ff;
    // reserved bits are masked so they always read back zero
    if (wr_hit && sel == 2'h2)
    begin
      nxt_ctrl_two = pwdata[6:0] & CTRL_TWO_MASK;
    end
    // control one keeps only its two crossover bits
    if (wr_hit && sel == 2'h1)
    begin
      nxt_ctrl_one = {pwdata[RAPID_XOVER_BIT], pwdata[HARD_XOVER_BIT]};
    end
    // hardware set wins over a software clear in the same cycle
    if (xover_on)
    begin
      nxt_ctrl_two[FAST_PD_BIT] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_two_ff <= CTRL_TWO_RESET;
      ctrl_one_ff <= CTRL_ONE_RESET;
    end
    else
    begin
      ctrl_two_ff <= nxt_ctrl_two;
      ctrl_one_ff <= nxt_ctrl_one;
    end
  end

  // zero-wait slave: the setup cycle prepares the answer for the access cycle
  always_comb
  begin
    nxt_pready = 1'b0;
    nxt_pslverr = 1'b0;
    nxt_prdata = prdata_ff;
    if (psel && !penable)
    begin
      nxt_pready = 1'b1;
      // status writes are answered but change nothing; unmapped ones flag an error
      nxt_pslverr = sel == 2'h0;
      nxt_prdata = '0;
      // data is captured at setup, so a read never sees a write still in flight
      if (!pwrite)
      begin
        unique case (sel)
          2'h1: nxt_prdata[RAPID_XOVER_BIT] = ctrl_one_ff[1];
          2'h2: nxt_prdata[6:0] = ctrl_two_ff;
          2'h3: nxt_prdata[REG_W-1:0] = status_word;
          2'h0: nxt_prdata = '0;
        endcase
        if (sel == 2'h1)
        begin
          nxt_prdata[HARD_XOVER_BIT] = ctrl_one_ff[0];
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= '0;
    end
    else
    begin
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      prdata_ff <= nxt_prdata;
    end
  end

  // parallel-detect qualification; the fast target is the short wait
  pcr_pd_timer #(
    .NORMAL_CYC(PD_NORMAL_CYCLES),
    .FAST_CYC(PD_FAST_CYC)
  ) u_pd_timer (
    .pclk(pclk),
    .presetn(presetn),
    .run(pd_active),
    .fast(ctrl_two_ff[FAST_PD_BIT]),
    .done(pd_done)
  );

  // extended ability only overrides when the partner is forced to 100
  always_comb
  begin
    fd_now = std_full_duplex;
    // the override needs a 100 link; a 10 link keeps the standard result
    if (ctrl_two_ff[FORCED_FD_BIT] && partner_forced_100 && speed_100)
    begin
      fd_now = 1'b1;
    end
  end

  // lamp, isolation and idle error gating settle one cycle after their inputs
  always_comb
  begin
    nxt_fd = fd_now;
    nxt_lamp = link_up;
    // strict lamp uses the resolved duplex, so a forced partner still counts
    if (ctrl_two_ff[LAMP_FD_BIT])
    begin
      nxt_lamp = link_up && speed_100 && fd_now;
    end
    nxt_iso = ctrl_two_ff[ISOLATE_HD_BIT] && link_up && speed_100 && !fd_now;
    // isolated outputs must not leak an error either
    nxt_rx_err = rx_symbol_err && (!rx_idle || ctrl_two_ff[IDLE_ERR_BIT])
      && !nxt_iso;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fd_ff <= 1'b0;
      lamp_ff <= 1'b0;
      iso_ff <= 1'b0;
      rx_err_ff <= 1'b0;
    end
    else
    begin
      fd_ff <= nxt_fd;
      lamp_ff <= nxt_lamp;
      iso_ff <= nxt_iso;
      rx_err_ff <= nxt_rx_err;
    end
  end

  // nibble parity tracker; one extra nibble closes an odd-length frame
  always_comb
  begin
    nxt_tx_state = tx_state_ff;
    nxt_odd = odd_ff;
    nxt_tx_en = tx_en_ff;
    nxt_tx_er = tx_er_ff;
    if (tx_clk_tick)
    begin
      nxt_tx_en = tx_en_in;
      nxt_tx_er = tx_er_in;
      unique case (tx_state_ff)
        TX_IDLE:
        begin
          nxt_odd = 1'b0;
          // a new frame starts its nibble count at one
          if (tx_en_in)
          begin
            nxt_tx_state = TX_SEND;
            nxt_odd = 1'b1;
          end
        end
        TX_SEND:
        begin
          if (tx_en_in)
          begin
            nxt_odd = !odd_ff;
          end
          else if (odd_ff && !ctrl_two_ff[ODD_NIB_OFF_BIT])
          begin
            // pad the odd nibble; the coder sees it as an error nibble
            nxt_tx_state = TX_EXTEND;
            nxt_tx_en = 1'b1;
            nxt_tx_er = 1'b1;
          end
          else
          begin
            nxt_tx_state = TX_IDLE;
          end
        end
        TX_EXTEND:
        begin
          // the pad nibble ends here whatever the mac does next
          nxt_tx_state = TX_IDLE;
          nxt_tx_en = 1'b0;
          nxt_tx_er = 1'b0;
          nxt_odd = 1'b0;
        end
      endcase
    end
    // isolation holds the transmit side quiet as well
    if (iso_ff)
    begin
      nxt_tx_en = 1'b0;
      nxt_tx_er = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_state_ff <= TX_IDLE;
      odd_ff <= 1'b0;
      tx_en_ff <= 1'b0;
      tx_er_ff <= 1'b0;
    end
    else
    begin
      tx_state_ff <= nxt_tx_state;
      odd_ff <= nxt_odd;
      tx_en_ff <= nxt_tx_en;
      tx_er_ff <= nxt_tx_er;
    end
  end

  // receive data capture on the selected reference
  pcr_rmii_sampler u_rmii (
    .pclk(pclk),
    .presetn(presetn),
    .rxd_in(rxd_in),
    .ref_tick(ref_clk_tick),
    .rx_clk_tick(rx_clk_tick),
    .use_rx_clk(ctrl_two_ff[RX_CLK_SEL_BIT]),
    .rxd_out(rxd_out),
    .rxd_strobe(rxd_strobe)
  );

  // outputs come straight from flops
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign full_duplex = fd_ff;
  assign link_lamp = lamp_ff;
  assign outputs_isolated = iso_ff;
  assign pd_link_ok = pd_done;
  assign rx_err_out = rx_err_ff;
  assign tx_en_out = tx_en_ff;
  assign tx_er_out = tx_er_ff;
endmodule

// ### design/pcr_pd_timer.sv
`timescale 1ns/100ps
module pcr_pd_timer #(
  parameter int unsigned NORMAL_CYC = pcr_pkg::PD_NORMAL_CYC,
  parameter int unsigned FAST_CYC = pcr_pkg::PD_FAST_CYC
) (
  input wire logic pclk, // bus clock
  input wire logic presetn, // async reset, active low
  input wire logic run, // parallel detection sees a partner
  input wire logic fast, // shortened qualification
  output logic done // link qualified, level
);
  import pcr_pkg::*;
  logic [PD_CNT_W-1:0] cnt_ff;
  logic [PD_CNT_W-1:0] nxt_cnt;
  logic done_ff;
  logic nxt_done;
  logic [PD_CNT_W-1:0] limit;

  // target follows the mode live, so a switch mid-count takes effect at once
  assign limit = fast ? PD_CNT_W'(FAST_CYC) : PD_CNT_W'(NORMAL_CYC);

  // count while the partner is present, restart when it goes
  always_comb
  begin
    nxt_cnt = cnt_ff;
    nxt_done = done_ff;
    if (!run)
    begin
      nxt_cnt = '0;
      nxt_done = 1'b0;
    end
    else if (cnt_ff + 1'b1 >= limit)
    begin
      nxt_done = 1'b1;
    end
    else
    begin
      nxt_cnt = cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_ff <= '0;
      done_ff <= 1'b0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      done_ff <= nxt_done;
    end
  end

  assign done = done_ff;
endmodule

// ### design/pcr_rmii_sampler.sv
`timescale 1ns/100ps
module pcr_rmii_sampler (
  input wire logic pclk, // bus clock
  input wire logic presetn, // async reset, active low
  input wire logic [1:0] rxd_in, // reduced-interface receive pair
  input wire logic ref_tick, // reference clock input edge
  input wire logic rx_clk_tick, // receive clock edge
  input wire logic use_rx_clk, // 1 = sample on receive clock
  output logic [1:0] rxd_out, // sampled pair
  output logic rxd_strobe // one-cycle pulse per sample
);
  logic [1:0] rxd_ff;
  logic [1:0] nxt_rxd;
  logic stb_ff;
  logic nxt_stb;
  logic take;

  // only the selected reference may capture data
  assign take = use_rx_clk ? rx_clk_tick : ref_tick;

  always_comb
  begin
    nxt_rxd = rxd_ff;
    nxt_stb = take;
    if (take)
    begin
      nxt_rxd = rxd_in;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rxd_ff <= 2'h0;
      stb_ff <= 1'b0;
    end
    else
    begin
      rxd_ff <= nxt_rxd;
      stb_ff <= nxt_stb;
    end
  end

  assign rxd_out = rxd_ff;
  assign rxd_strobe = stb_ff;
endmodule

// ### inc/pcr_pkg.sv
package pcr_pkg;
  // bus geometry
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W = 16;
  // register indices; the byte address is four times the index
  localparam logic [ADDR_W-1:0] CTRL_ONE_IDX = 12'h009;
  localparam logic [ADDR_W-1:0] CTRL_TWO_IDX = 12'h00a;
  localparam logic [ADDR_W-1:0] STATUS_IDX = 12'h010;
  localparam logic [ADDR_W-1:0] CTRL_ONE_ADDR = 12'h024;
  localparam logic [ADDR_W-1:0] CTRL_TWO_ADDR = 12'h028;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 12'h040;
  // control two field positions
  localparam int unsigned FAST_PD_BIT = 6;
  localparam int unsigned FORCED_FD_BIT = 5;
  localparam int unsigned LAMP_FD_BIT = 4;
  localparam int unsigned ISOLATE_HD_BIT = 3;
  localparam int unsigned IDLE_ERR_BIT = 2;
  localparam int unsigned ODD_NIB_OFF_BIT = 1;
  localparam int unsigned RX_CLK_SEL_BIT = 0;
  localparam logic [6:0] CTRL_TWO_MASK = 7'h7f;
  localparam logic [6:0] CTRL_TWO_RESET = 7'h04;
  // control one field positions (crossover modes)
  localparam int unsigned RAPID_XOVER_BIT = 6;
  localparam int unsigned HARD_XOVER_BIT = 5;
  localparam logic [1:0] CTRL_ONE_RESET = 2'h0;
  // status field positions
  localparam int unsigned ST_FD_BIT = 0;
  localparam int unsigned ST_LAMP_BIT = 1;
  localparam int unsigned ST_ISO_BIT = 2;
  localparam int unsigned ST_PD_LINK_BIT = 3;
  localparam int unsigned ST_TX_EXT_BIT = 4;
  // timing
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned PD_NORMAL_US = 500;
  localparam int unsigned PD_FAST_US = 50;
  localparam int unsigned PD_NORMAL_CYC = (PD_NORMAL_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned PD_FAST_CYC = (PD_FAST_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned PD_CNT_W = 16;
  // transmit enable tracker states
  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_SEND = 3'b010,
    TX_EXTEND = 3'b100
  } pcr_tx_state_t;
  // address decode used by read and write paths
  function automatic logic [1:0] pcr_decode(input logic [ADDR_W-1:0] addr);
    unique case (addr)
      CTRL_ONE_ADDR: pcr_decode = 2'h1;
      CTRL_TWO_ADDR: pcr_decode = 2'h2;
      STATUS_ADDR: pcr_decode = 2'h3;
      default: pcr_decode = 2'h0;
    endcase
  endfunction
endpackage

// ### test/pcr_checker.sv
`timescale 1ns/100ps
module pcr_checker #(
  parameter int unsigned PD_NORMAL_CYCLES = pcr_pkg::PD_NORMAL_CYC // normal qualify wait
) (
  input wire logic pclk, // bus clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic link_up, // link up
  input wire logic speed_100, // 100 link
  input wire logic partner_forced_100, // forced partner
  input wire logic std_full_duplex, // standard duplex
  input wire logic rx_symbol_err, // symbol error
  input wire logic pd_active, // parallel detect
  input wire logic full_duplex, // duplex out
  input wire logic link_lamp, // lamp out
  input wire logic outputs_isolated, // isolation out
  input wire logic rx_err_out, // error out
  input wire logic pd_link_ok // qualified link
);
  import pcr_pkg::*;
  logic [15:0] run_ff;
  logic [15:0] nxt_run;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // consecutive detect cycles; saturates so a stuck input cannot wrap
  always_comb
  begin
    nxt_run = !pd_active ? 16'h0 : ((&run_ff) ? run_ff : run_ff + 16'h1);
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      run_ff <= 16'h0;
    else
      run_ff <= nxt_run;
  end
  zero_wait_a: assert property (psel && !penable |=> pready)
    else $error("ready missing in access cycle");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  lamp_needs_link_a: assert property (!link_up |=> !link_lamp)
    else $error("lamp lit without link");
  iso_speed_a: assert property (!speed_100 |=> !outputs_isolated)
    else $error("isolated off 100 link");
  iso_half_a: assert property (outputs_isolated |-> !full_duplex)
    else $error("isolated on full duplex");
  std_duplex_a: assert property (!partner_forced_100 |=>
    full_duplex == $past(std_full_duplex))
    else $error("duplex not standard");
  rx_err_cause_a: assert property (!rx_symbol_err |=> !rx_err_out)
    else $error("receive error without cause");
  pd_drop_a: assert property (!pd_active |=> !pd_link_ok)
    else $error("qualified link without detect");
  pd_early_a: assert property ($rose(pd_link_ok) |-> run_ff >= 16'(PD_FAST_CYC - 4))
    else $error("link qualified too early");
  pd_late_a: assert property (run_ff == 16'(PD_NORMAL_CYCLES + 4) |-> pd_link_ok)
    else $error("link qualified too late");
  cover property (pready && pslverr);
  cover property ($rose(pd_link_ok));
  cover property (outputs_isolated);
endmodule

// ### test/pcr_mac_model.sv
`timescale 1ns/100ps
module pcr_mac_model (
  input wire logic pclk, // bus clock
  input wire logic presetn, // reset, active low
  input wire logic start, // begin a frame
  input wire logic [3:0] nibbles, // frame length
  output logic tx_en, // transmit enable
  output logic tx_er, // transmit error
  output logic tx_tick, // transmit clock pulse
  output logic [1:0] rxd, // receive pair
  output logic ref_tick, // reference clock pulse
  output logic rx_tick // receive clock pulse
);
  logic [1:0] cnt_ff;
  logic [3:0] left_ff;
  // enable drops only at a transmit edge; a start loads the length and raises it at any edge
  assign tx_en = left_ff != 4'h0;
  assign tx_er = 1'b0;
  assign tx_tick = cnt_ff[0];
  // data changes every cycle so the chosen clock shows in the sample
  assign rxd = cnt_ff;
  assign ref_tick = cnt_ff == 2'h0;
  assign rx_tick = cnt_ff == 2'h2;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_ff <= 2'h0;
      left_ff <= 4'h0;
    end
    else
    begin
      cnt_ff <= cnt_ff + 2'h1;
      if (start)
        left_ff <= nibbles;
      else if (tx_tick && tx_en)
        left_ff <= left_ff - 4'h1;
    end
  end
endmodule

// ### test/phy_control_register_two_test.sv
`timescale 1ns/100ps
module phy_control_register_two_test;
  import pcr_pkg::*;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pd_active, go, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, d, ex;
  logic pready, pslverr, full_duplex, link_lamp, outputs_isolated, pd_link_ok;
  logic rx_err_out, tx_en_out, tx_er_out, rxd_strobe, tx_en_in, tx_er_in;
  logic tx_clk_tick, ref_clk_tick, rx_clk_tick;
  logic link_up, speed_100, partner_forced_100, std_full_duplex, rx_idle, rx_symbol_err;
  logic [1:0] rxd_in, rxd_out;
  logic [3:0] nib, lk;
  logic [5:0] lv;
  logic [12:0] cor [3];
  int bad_count, total_checks, en_n, er_n, a, b, n;
  pcr_control_two #(.PD_NORMAL_CYCLES(2000)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link_up(link_up), .speed_100(speed_100),
    .pd_active(pd_active), .partner_forced_100(partner_forced_100),
    .std_full_duplex(std_full_duplex), .rx_idle(rx_idle), .rx_symbol_err(rx_symbol_err),
    .tx_en_in(tx_en_in), .tx_er_in(tx_er_in), .tx_clk_tick(tx_clk_tick), .rxd_in(rxd_in),
    .ref_clk_tick(ref_clk_tick), .rx_clk_tick(rx_clk_tick), .full_duplex(full_duplex),
    .link_lamp(link_lamp), .outputs_isolated(outputs_isolated), .pd_link_ok(pd_link_ok),
    .rx_err_out(rx_err_out), .tx_en_out(tx_en_out), .tx_er_out(tx_er_out),
    .rxd_out(rxd_out), .rxd_strobe(rxd_strobe));
  pcr_mac_model mac_u (.pclk(pclk), .presetn(presetn), .start(go), .nibbles(nib),
    .tx_en(tx_en_in), .tx_er(tx_er_in), .tx_tick(tx_clk_tick), .rxd(rxd_in),
    .ref_tick(ref_clk_tick), .rx_tick(rx_clk_tick));
  assign {link_up, speed_100, partner_forced_100, std_full_duplex, rx_idle, rx_symbol_err} = lv;
  assign lk = {full_duplex, link_lamp, outputs_isolated, rx_err_out};
  always #25 pclk = ~pclk;
  // running totals; frames start and end idle so snapshots need no edge care
  always @(posedge pclk)
  begin
    en_n += tx_en_out;
    er_n += tx_er_out;
  end
  task automatic print_verdict();
    if (bad_count == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic limit(input int k);
    if (k >= 20)
    begin
      bad_count++;
      print_verdict();
    end
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    total_checks++;
    if (s !== x)
    begin
      bad_count++;
      $display("ERROR at %0t seen %h expected %h", $time, s, x);
    end
  endtask
  // leading edge wait keeps a release and the next setup in separate steps
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    limit(k);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // v is link, speed, forced partner, standard duplex, idle, symbol error
  function automatic logic [31:0] exp_out(input logic [6:0] c, input logic [5:0] v);
    logic f;
    logic i;
    f = (c[5] & v[4] & v[3]) | v[2];
    i = c[3] & v[5] & v[4] & ~f;
    exp_out = {28'h0, f, c[4] ? v[5] & v[4] & f : v[5], i, v[0] & (~v[1] | c[2]) & ~i};
  endfunction
  initial
  begin
    {psel, penable, pwrite, pd_active, go, presetn} = 6'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    lv = 6'h0;
    nib = 4'h0;
    cor = '{{7'h20, 6'h38}, {7'h08, 6'h39}, {7'h10, 6'h3c}};
    void'($urandom(32'hc9af));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, CTRL_TWO_ADDR, 32'h0);
    chk(rd, 32'h4);
    apb(1'b0, CTRL_ONE_ADDR, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h100, 32'h0);
    chk({31'h0, er}, 32'h1);
    apb(1'b1, CTRL_TWO_ADDR, 32'hffff_ffff);
    apb(1'b0, CTRL_TWO_ADDR, 32'h0);
    chk(rd, 32'h7f);
    for (int i = 0; i < 2; i++)
    begin
      apb(1'b1, CTRL_ONE_ADDR, 32'h20 << i);
      apb(1'b1, CTRL_TWO_ADDR, 32'h0);
      apb(1'b0, CTRL_TWO_ADDR, 32'h0);
      chk(rd, 32'h40);
    end
    apb(1'b1, CTRL_ONE_ADDR, 32'h0);
    // corner settings first, then random ones
    for (int i = 0; i < 43; i++)
    begin
      d = (i < 3) ? {25'h0, cor[i % 3][12:6]} : $urandom;
      apb(1'b1, CTRL_TWO_ADDR, d);
      apb(1'b0, CTRL_TWO_ADDR, 32'h0);
      chk(rd, {25'h0, d[6:0]});
      lv <= (i < 3) ? cor[i % 3][5:0] : 6'($urandom);
      repeat (2) @(posedge pclk);
      chk({28'h0, lk}, exp_out(d[6:0], lv));
      ex = exp_out(d[6:0], lv);
      apb(1'b0, STATUS_ADDR, 32'h0);
      chk(rd, {29'h0, ex[1], ex[2], ex[3]});
    end
    lv <= 6'h0;
    for (int i = 0; i < 2; i++)
    begin
      apb(1'b1, CTRL_TWO_ADDR, 32'(i) << 6);
      pd_active <= 1'b1;
      repeat (1100) @(posedge pclk);
      chk({31'h0, pd_link_ok}, 32'(i));
      repeat (1000) @(posedge pclk);
      chk({31'h0, pd_link_ok}, 32'h1);
      apb(1'b0, STATUS_ADDR, 32'h0);
      chk({31'h0, rd[ST_PD_LINK_BIT]}, 32'h1);
      pd_active <= 1'b0;
      repeat (2) @(posedge pclk);
      chk({31'h0, pd_link_ok}, 32'h0);
    end
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, CTRL_TWO_ADDR, 32'(i & 2));
      a = en_n;
      b = er_n;
      nib <= 4'(3 + (i & 1));
      go <= 1'b1;
      @(posedge pclk);
      go <= 1'b0;
      repeat (30) @(posedge pclk);
      n = (i == 0) ? 1 : 0;
      chk(32'(en_n - a), 32'(2 * (3 + (i & 1) + n)));
      chk(32'(er_n - b), 32'(2 * n));
    end
    for (int i = 0; i < 2; i++)
    begin
      apb(1'b1, CTRL_TWO_ADDR, 32'(i));
      repeat (8) @(posedge pclk);
      n = 0;
      while (rxd_strobe !== 1'b1 && n < 20)
      begin
        @(posedge pclk);
        n++;
      end
      limit(n);
      chk({30'h0, rxd_out}, 32'(2 * i));
    end
    print_verdict();
  end
endmodule
bind pcr_control_two pcr_checker #(.PD_NORMAL_CYCLES(PD_NORMAL_CYCLES)) chk_u (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .link_up(link_up), .speed_100(speed_100), .partner_forced_100(partner_forced_100),
  .std_full_duplex(std_full_duplex), .rx_symbol_err(rx_symbol_err), .pd_active(pd_active),
  .full_duplex(full_duplex), .link_lamp(link_lamp), .outputs_isolated(outputs_isolated),
  .rx_err_out(rx_err_out), .pd_link_ok(pd_link_ok));
